// *** hdl/watchdog_pkg.sv ***
// constants, types and helpers shared by the watchdog key and control logic
// ----------------------------------------------------------------------------
// Behaviour
// - key write 0x55 then 0xAA clears the watchdog count to zero.
// - a key write of any other value does nothing unless a 0x55 came just before.
// - a write other than 0x55 or 0xAA after 0x55 abandons the sequence; restart with 0x55.
// - reading the key register returns the control register contents.
// - key and control writes need protected-write permission, else ignored.
// - control bit 7 reads 1 when the last reset came from the watchdog.
// - the reset status flag clears on writing 1; writing 0 does nothing.
// - disable bit 6 resets to 0; 1 disables, 0 enables the watchdog.
// - the disable bit changes only while the disable-unlock bit is 1.
// - while enabled, a wrong check field starts a reset or interrupt at once.
// - check field bits always read zero.
// - counting clock is oscillator/512, then /1,/1,/2 .. /64; code 000 at reset.
// - external reset pin low forces the reset status flag to 0.
// - flag sets on synced reset-output rise after 8192 cycles, pin high.
// - 8-bit counter increments at counting rate; overflow starts reset/interrupt.
// - mode 0 drives reset output low 512 cycles; mode 1 the interrupt output.
// - disable-unlock sets at reset, clears on writing 1, then stays clear.
// ----------------------------------------------------------------------------
`default_nettype none

package watchdog_pkg;

    // ------------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------------
    localparam int          ADDR_W      = 5;
    localparam logic [4:0]  ADDR_KEY    = 5'h00;
    localparam logic [4:0]  ADDR_CTRL   = 5'h04;
    localparam logic [4:0]  ADDR_SYSCTL = 5'h08;
    localparam logic [4:0]  ADDR_COUNT  = 5'h0C;

    // ------------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------------
    localparam int FLAG_BIT   = 7;
    localparam int DIS_BIT    = 6;
    localparam int CHK_HI     = 5;
    localparam int CHK_LO     = 3;
    localparam int PS_HI      = 2;
    localparam int PS_LO      = 0;
    localparam int INTS_BIT   = 2;
    localparam int MODE_BIT   = 1;
    localparam int UNLOCK_BIT = 0;

    localparam logic [7:0] KEY_FIRST     = 8'h55;
    localparam logic [7:0] KEY_SECOND    = 8'hAA;
    localparam logic [2:0] CHECK_PATTERN = 3'h5;

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [2:0] PS_RESET     = 3'h0;
    localparam logic       DIS_RESET    = 1'h0;
    localparam logic       UNLOCK_RESET = 1'h1;
    localparam logic       MODE_RESET   = 1'h0;
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;

    // ------------------------------------------------------------------------
    // timing, in core clock cycles (oscillator clock is the core clock)
    // ------------------------------------------------------------------------
    localparam int OSC_PRESCALE       = 512;
    localparam int PULSE_LEN          = 512;
    localparam int FLAG_DELAY_DEFAULT = 8192;

    typedef enum logic [1:0]
    {
        KEY_IDLE  = 2'b01,
        KEY_ARMED = 2'b10
    } key_state_t;

    // control register image; check bits and upper byte always read zero
    function automatic logic [15:0] ctrl_word(input logic       flag,
                                              input logic       dis,
                                              input logic [2:0] ps);
        ctrl_word = {8'h00, flag, dis, 3'h0, ps};
    endfunction

endpackage

`default_nettype wire

// *** hdl/counting_clock_divider.sv ***
// prescaler making the one-cycle counting clock enable
`timescale 1ns/10ps
`default_nettype none

module counting_clock_divider
    import watchdog_pkg::*;
#(
    parameter int BASE_DIV = OSC_PRESCALE
)
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] prescale_select,
    // enable out
    output logic            count_tick
);

    localparam int BW = $clog2(BASE_DIV);

    typedef struct packed
    {
        logic [BW-1:0] base;
        logic [5:0]    div;
        logic          tick;
    } div_state_t;

    div_state_t s;
    div_state_t next_s;

    // last value of the second stage: codes 000 and 001 both divide by one
    function automatic logic [5:0] divisor_last(input logic [2:0] code);
        logic [6:0] d;
        d = 7'h01 << (code - 3'h1);
        if (code <= 3'h1)
            divisor_last = 6'h00;
        else
            divisor_last = 6'(d - 7'h01);
    endfunction

    always_comb
    begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!run)
        begin
            next_s.base = '0;
            next_s.div  = 6'h00;
        end
        else if (s.base == BW'(BASE_DIV - 1))
        begin
            next_s.base = '0;
            // >= so that lowering the divisor mid-count cannot stall
            if (s.div >= divisor_last(prescale_select))
            begin
                next_s.div  = 6'h00;
                next_s.tick = 1'b1;
            end
            else
                next_s.div = s.div + 6'h01;
        end
        else
            next_s.base = s.base + BW'(1);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign count_tick = s.tick;

endmodule // counting_clock_divider

`default_nettype wire

// *** hdl/watchdog_key_and_control.sv ***
// watchdog key and control registers, counter and reset pulse logic
`timescale 1ns/10ps
`default_nettype none

module watchdog_key_and_control
    import watchdog_pkg::*;
#(
    parameter int FLAG_DELAY = FLAG_DELAY_DEFAULT
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // system side
    input  wire logic              protected_write_permission,
    input  wire logic              external_reset_pin_n,
    output logic                   watchdog_reset_output_n,
    output logic                   watchdog_interrupt_output_n
);

    localparam int DLY_W = $clog2(FLAG_DELAY + 1);
    localparam int PW    = $clog2(PULSE_LEN);

    typedef struct packed
    {
        logic             ack;
        logic [31:0]      rdata;
        key_state_t       key;
        logic [7:0]       count;
        logic             flag;
        logic             dis;
        logic [2:0]       ps;
        logic             int_mode;
        logic             unlock;
        logic             pulse;
        logic [PW-1:0]    pulse_cnt;
        logic             rst_n;
        logic             int_n;
        logic             sync1;
        logic             sync2;
        logic             sync_prev;
        logic             dly_run;
        logic [DLY_W-1:0] dly_cnt;
    } wd_state_t;

    localparam wd_state_t RESET_STATE = '{
        ack:       1'b0,
        rdata:     32'h00000000,
        key:       KEY_IDLE,
        count:     COUNT_RESET,
        flag:      1'b0,
        dis:       DIS_RESET,
        ps:        PS_RESET,
        int_mode:  MODE_RESET,
        unlock:    UNLOCK_RESET,
        pulse:     1'b0,
        pulse_cnt: '0,
        rst_n:     1'b1,
        int_n:     1'b1,
        sync1:     1'b1,
        sync2:     1'b1,
        sync_prev: 1'b1,
        dly_run:   1'b0,
        dly_cnt:   '0
    };

    wd_state_t s;
    wd_state_t next_s;

    logic       req;
    logic       accept_wr;
    logic       accept_rd;
    logic       wr_lane0;
    logic       key_wr;
    logic       ctrl_wr;
    logic       sys_wr;
    logic [7:0] wbyte;
    logic       key_clear;
    logic       check_bad;
    logic       tick;
    logic       tick_en;
    logic       overflow;
    logic       rst_rise;
    logic       flag_set;

    // ------------------------------------------------------------------------
    // bus decode: one wait state, read data latched in the wait cycle
    // ------------------------------------------------------------------------
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~s.ack;
    assign accept_wr       = avs_write & s.ack;
    assign accept_rd       = avs_read & s.ack;
    assign wbyte           = avs_writedata[7:0];
    // upper byte lanes carry only reserved bits, so lane 0 alone matters
    assign wr_lane0        = accept_wr & avs_byteenable[0] & protected_write_permission;
    assign key_wr          = wr_lane0 & (avs_address == ADDR_KEY);
    assign ctrl_wr         = wr_lane0 & (avs_address == ADDR_CTRL);
    assign sys_wr          = wr_lane0 & (avs_address == ADDR_SYSCTL);
    assign avs_readdata    = s.rdata;

    assign key_clear = key_wr & (s.key == KEY_ARMED) & (wbyte == KEY_SECOND);
    // software relies on this to force a reset on purpose
    assign check_bad = ctrl_wr & ~s.dis & (wbyte[CHK_HI:CHK_LO] != CHECK_PATTERN);
    assign tick_en   = tick & ~s.dis;
    assign overflow  = tick_en & (s.count == COUNT_MAX);
    assign rst_rise  = s.sync2 & ~s.sync_prev;
    assign flag_set  = s.dly_run & (s.dly_cnt == DLY_W'(FLAG_DELAY - 1));

    // ------------------------------------------------------------------------
    // counting clock
    // ------------------------------------------------------------------------
    counting_clock_divider #(
        .BASE_DIV        (OSC_PRESCALE)
    ) u_div (
        .core_clk        (core_clk),
        .rst             (rst),
        .run             (~s.dis),
        .prescale_select (s.ps),
        .count_tick      (tick)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s     = s;
        next_s.ack = req & ~s.ack;

        if (req & ~s.ack)
        begin
            case (avs_address)
                ADDR_KEY:    next_s.rdata = 32'(ctrl_word(s.flag, s.dis, s.ps));
                ADDR_CTRL:   next_s.rdata = 32'(ctrl_word(s.flag, s.dis, s.ps));
                ADDR_SYSCTL: next_s.rdata = 32'({s.int_n, s.int_mode, s.unlock});
                ADDR_COUNT:  next_s.rdata = 32'(s.count);
                default:     next_s.rdata = 32'h00000000;
            endcase
        end

        // key sequence tracker
        if (key_wr)
        begin
            case (s.key)
                KEY_IDLE:
                begin
                    if (wbyte == KEY_FIRST)
                        next_s.key = KEY_ARMED;
                end
                KEY_ARMED:
                begin
                    // a repeated first key keeps the sequence armed
                    if (wbyte != KEY_FIRST)
                        next_s.key = KEY_IDLE;
                end
                default:
                    next_s.key = KEY_IDLE;
            endcase
        end

        if (key_clear)
            next_s.count = COUNT_RESET;
        else if (tick_en)
            next_s.count = s.count + 8'h01;

        // reset or interrupt pulse; a new cause during a pulse is absorbed
        if (s.pulse)
        begin
            if (s.pulse_cnt == PW'(PULSE_LEN - 1))
            begin
                next_s.pulse     = 1'b0;
                next_s.pulse_cnt = '0;
            end
            else
                next_s.pulse_cnt = s.pulse_cnt + PW'(1);
        end
        else if (overflow | check_bad)
        begin
            next_s.pulse     = 1'b1;
            next_s.pulse_cnt = '0;
        end

        if (ctrl_wr)
        begin
            if (s.unlock)
                next_s.dis = wbyte[DIS_BIT];
            next_s.ps = wbyte[PS_HI:PS_LO];
        end

        if (sys_wr)
        begin
            next_s.int_mode = wbyte[MODE_BIT];
            if (wbyte[UNLOCK_BIT])
                next_s.unlock = 1'b0;
        end

        // reset output edge: synchronise, then wait before marking the cause
        next_s.sync1     = s.rst_n;
        next_s.sync2     = s.sync1;
        next_s.sync_prev = s.sync2;
        if (rst_rise)
        begin
            next_s.dly_run = 1'b1;
            next_s.dly_cnt = '0;
        end
        else if (flag_set)
            next_s.dly_run = 1'b0;
        else if (s.dly_run)
            next_s.dly_cnt = s.dly_cnt + DLY_W'(1);

        // the pin wins over everything, a set wins over a software clear
        if (ctrl_wr & wbyte[FLAG_BIT])
            next_s.flag = 1'b0;
        if (flag_set)
            next_s.flag = 1'b1;
        if (~external_reset_pin_n)
            next_s.flag = 1'b0;

        // a mode change mid-pulse moves the pulse to the other output
        next_s.rst_n = ~(next_s.pulse & ~next_s.int_mode);
        next_s.int_n = ~(next_s.pulse & next_s.int_mode);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            s <= RESET_STATE;
        else
            s <= next_s;
    end

    assign watchdog_reset_output_n     = s.rst_n;
    assign watchdog_interrupt_output_n = s.int_n;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_key_clear;
        key_clear |=> s.count == COUNT_RESET;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key pair did not clear count");

    property p_key_other;
        key_wr && s.key == KEY_IDLE && wbyte != KEY_FIRST |=> $stable(s.key);
    endproperty
    a_key_other: assert property (p_key_other) else $error("stray key byte had effect");

    property p_key_abandon;
        key_wr && s.key == KEY_ARMED && wbyte != KEY_SECOND && wbyte != KEY_FIRST
            |=> s.key == KEY_IDLE ##1 s.count != COUNT_RESET || !key_clear;
    endproperty
    a_key_abandon: assert property (p_key_abandon) else $error("sequence not abandoned");

    property p_key_read;
        accept_rd && avs_address == ADDR_KEY
            |-> avs_readdata == 32'(ctrl_word($past(s.flag), $past(s.dis), $past(s.ps)));
    endproperty
    a_key_read: assert property (p_key_read) else $error("key read not control image");

    property p_ctrl_zero;
        accept_rd && avs_address == ADDR_CTRL
            |-> avs_readdata[31:8] == 24'h000000 && avs_readdata[CHK_HI:CHK_LO] == 3'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("check or upper bits nonzero");

    property p_protect;
        accept_wr && !protected_write_permission
            |=> $stable(s.dis) && $stable(s.ps) && $stable(s.key) && $stable(s.unlock);
    endproperty
    a_protect: assert property (p_protect) else $error("unprotected write took effect");

    property p_flag_hold;
        s.flag && ctrl_wr && !wbyte[FLAG_BIT] && external_reset_pin_n |=> s.flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("writing 0 cleared flag");

    property p_dis_locked;
        ctrl_wr && !s.unlock |=> $stable(s.dis);
    endproperty
    a_dis_locked: assert property (p_dis_locked) else $error("disable changed while locked");

    property p_disabled_count;
        s.dis && !key_clear |=> $stable(s.count);
    endproperty
    a_disabled_count: assert property (p_disabled_count) else $error("count ran disabled");

    property p_check;
        check_bad && !s.pulse
            |=> !watchdog_reset_output_n || !watchdog_interrupt_output_n;
    endproperty
    a_check: assert property (p_check) else $error("bad check field ignored");

    property p_overflow;
        overflow && !s.pulse |=> s.pulse && s.pulse_cnt == PW'(0);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow pulse did not start");

    // pulse length is checked step by step: a 512-cycle delay is too long to unroll
    property p_pulse_step;
        s.pulse && s.pulse_cnt != PW'(PULSE_LEN - 1)
            |=> s.pulse && s.pulse_cnt == $past(s.pulse_cnt) + PW'(1);
    endproperty
    a_pulse_step: assert property (p_pulse_step) else $error("pulse ended early");

    property p_pulse_end;
        s.pulse && s.pulse_cnt == PW'(PULSE_LEN - 1) |=> !s.pulse;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse ran too long");

    property p_int_route;
        !watchdog_interrupt_output_n |-> s.pulse && s.int_mode && watchdog_reset_output_n;
    endproperty
    a_int_route: assert property (p_int_route) else $error("interrupt out in reset mode");

    property p_ext_flag;
        !external_reset_pin_n |=> !s.flag;
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("flag set with pin low");

    property p_flag_cause;
        $rose(s.flag) |-> $past(flag_set) && $past(external_reset_pin_n);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without cause");

    property p_unlock_sticky;
        !s.unlock |=> !s.unlock;
    endproperty
    a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock bit came back");

    c_key_clear: cover property (key_clear);
    c_check_reset: cover property (check_bad && !s.int_mode);
    c_overflow: cover property (overflow);
    c_flag_set: cover property ($rose(s.flag));

endmodule // watchdog_key_and_control

`default_nettype wire

// *** tb/board_reset_model.sv ***
// board reset model: reset pin wired from the watchdog reset output
`timescale 1ns/10ps
`default_nettype none

module board_reset_model
(
    // watchdog side
    input  wire logic watchdog_reset_output_n,
    // board side
    input  wire logic hold_external,
    output logic      external_reset_pin_n
);
    // pulled-up line; either source pulls it low
    // the bench stretches an external hold past the watchdog pulse
    assign external_reset_pin_n = watchdog_reset_output_n & ~hold_external;
endmodule // board_reset_model

`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the watchdog key and control block
`timescale 1ns/10ps
`default_nettype none

module testbench
    import watchdog_pkg::*;
;
    localparam int FD = 16;
    logic              core_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata, rd, junk;
    logic [3:0]        avs_byteenable;
    logic              protected_write_permission, hold_external;
    logic              external_reset_pin_n;
    logic              watchdog_reset_output_n, watchdog_interrupt_output_n;
    logic [1:0]        outs;
    logic [7:0]        v;
    int                n_errors = 0;
    int                n_checks = 0;
    int                run[2] = '{0, 0};
    int                plen[2] = '{0, 0};
    int                pcnt[2] = '{0, 0};

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    watchdog_key_and_control #(.FLAG_DELAY(FD)) i_dut
    (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .protected_write_permission(protected_write_permission),
        .external_reset_pin_n(external_reset_pin_n),
        .watchdog_reset_output_n(watchdog_reset_output_n),
        .watchdog_interrupt_output_n(watchdog_interrupt_output_n)
    );

    board_reset_model i_board
    (
        .watchdog_reset_output_n(watchdog_reset_output_n),
        .hold_external(hold_external),
        .external_reset_pin_n(external_reset_pin_n)
    );

    // pulse monitor: index 0 reset output, 1 interrupt output
    assign outs = {watchdog_interrupt_output_n, watchdog_reset_output_n};
    always @(posedge core_clk)
    begin
        for (int j = 0; j < 2; j++)
        begin
            run[j] <= (outs[j] === 1'b0) ? run[j] + 1 : 0;
            if (outs[j] === 1'b1 && run[j] != 0)
            begin
                plen[j] <= run[j];
                pcnt[j] <= pcnt[j] + 1;
            end
        end
    end

    function automatic logic [31:0] ctrl_exp(input logic f, input logic d, input logic [2:0] p);
        return {24'h000000, f, d, 3'h0, p};
    endfunction

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one access; upper write bits are junk that must be ignored
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        junk = $urandom();
        avs_address <= a;
        avs_writedata <= {junk[23:0], d};
        avs_read <= ~wr;
        avs_write <= wr;
        // waitrequest is judged at the rising edge; only the watchdog ends a hang
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // idle cycle so the next request never lands in the release step
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        chk(rd, exp, what);
    endtask

    task automatic count_kept();
        bus(1'b0, ADDR_COUNT, 8'h00);
        chk({31'h0, rd[7:0] != 8'h00}, 32'h1, "count kept");
    endtask

    task automatic rnd_key();
        v = 8'(($urandom_range(255)));
        while (v == KEY_FIRST || v == KEY_SECOND)
            v = 8'(($urandom_range(255)));
    endtask

    task automatic expect_pulse(input int w, input int n_exp);
        int c0, c1, k;
        c0 = pcnt[0];
        c1 = pcnt[1];
        k = 0;
        while (pcnt[0] == c0 && pcnt[1] == c1 && k < 600)
        begin
            @(posedge core_clk);
            k++;
        end
        chk(pcnt[w] - (w ? c1 : c0), n_exp, "pulse count");
        chk(pcnt[1 - w] - (w ? c0 : c1), 0, "other output");
        if (n_exp > 0)
            chk(plen[w], PULSE_LEN, "pulse length");
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        protected_write_permission = 1'b0;
        hold_external = 1'b0;
        void'($urandom(32'hF8097514));
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 3'h0), "ctrl reset");
        rdchk(ADDR_SYSCTL, 32'h00000005, "sysctl reset");
        bus(1'b1, ADDR_CTRL, 8'h00);
        expect_pulse(0, 0);
        protected_write_permission <= 1'b1;
        avs_byteenable <= 4'hE;
        bus(1'b1, ADDR_CTRL, 8'h00);
        expect_pulse(0, 0);
        avs_byteenable <= 4'hF;
        for (int i = 7; i >= 0; i--)
        begin
            bus(1'b1, ADDR_CTRL, {2'b00, CHECK_PATTERN, 3'(i)});
            rdchk(ADDR_KEY, ctrl_exp(1'b0, 1'b0, 3'(i)), "key image");
        end
        // key sequences once the count has moved
        repeat (1100) @(posedge core_clk);
        protected_write_permission <= 1'b0;
        bus(1'b1, ADDR_KEY, KEY_FIRST);
        bus(1'b1, ADDR_KEY, KEY_SECOND);
        protected_write_permission <= 1'b1;
        count_kept();
        repeat (4)
        begin
            rnd_key();
            bus(1'b1, ADDR_KEY, v);
        end
        count_kept();
        bus(1'b1, ADDR_KEY, KEY_FIRST);
        rnd_key();
        bus(1'b1, ADDR_KEY, v);
        bus(1'b1, ADDR_KEY, KEY_SECOND);
        count_kept();
        bus(1'b1, ADDR_KEY, KEY_FIRST);
        bus(1'b1, ADDR_KEY, KEY_SECOND);
        rdchk(ADDR_COUNT, 32'h00000000, "count clear");
        repeat (1636) @(posedge core_clk);
        bus(1'b0, ADDR_COUNT, 8'h00);
        chk({31'h0, rd == 32'h3 || rd == 32'h4}, 32'h1, "count rate");
        // disable bit and its unlock
        bus(1'b1, ADDR_CTRL, 8'h68);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b1, 3'h0), "disable set");
        bus(1'b1, ADDR_CTRL, 8'h40);
        expect_pulse(0, 0);
        bus(1'b1, ADDR_CTRL, 8'h28);
        bus(1'b1, ADDR_SYSCTL, 8'h01);
        bus(1'b1, ADDR_SYSCTL, 8'h00);
        rdchk(ADDR_SYSCTL, 32'h00000004, "unlock cleared");
        bus(1'b1, ADDR_CTRL, 8'h68);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 3'h0), "disable locked");
        // software reset through a bad check field
        bus(1'b1, ADDR_CTRL, 8'h00);
        expect_pulse(0, 1);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 3'h0), "flag delayed");
        repeat (FD + 10) @(posedge core_clk);
        rdchk(ADDR_CTRL, ctrl_exp(1'b1, 1'b0, 3'h0), "flag set");
        bus(1'b1, ADDR_CTRL, 8'h28);
        rdchk(ADDR_CTRL, ctrl_exp(1'b1, 1'b0, 3'h0), "flag kept");
        bus(1'b1, ADDR_CTRL, 8'hA8);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 3'h0), "flag cleared");
        hold_external <= 1'b1;
        bus(1'b1, ADDR_CTRL, 8'h00);
        expect_pulse(0, 1);
        repeat (FD + 10) @(posedge core_clk);
        hold_external <= 1'b0;
        repeat (FD + 10) @(posedge core_clk);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 3'h0), "flag held low");
        // interrupt mode
        bus(1'b1, ADDR_SYSCTL, 8'h02);
        bus(1'b1, ADDR_CTRL, 8'h00);
        expect_pulse(1, 1);
        rdchk(ADDR_SYSCTL, 32'h00000006, "mode status");
        repeat (FD + 10) @(posedge core_clk);
        rdchk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 3'h0), "no flag on int");
        // reset in mid-sequence
        bus(1'b1, ADDR_KEY, KEY_FIRST);
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdchk(ADDR_SYSCTL, 32'h00000005, "sysctl again");
        repeat (1100) @(posedge core_clk);
        bus(1'b1, ADDR_KEY, KEY_SECOND);
        count_kept();
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
